// ===== snsid_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// shared constants for the sensor identification and attention scan ends
package snsid_pkg;

  // register offsets (internal register address, 6 bits)
  localparam logic [5:0]  REG_BUS_ADDR   = 6'h00;
  localparam logic [5:0]  REG_MAKER      = 6'h01;
  localparam logic [5:0]  REG_PART_REV   = 6'h02;
  localparam logic [5:0]  REG_CAPS       = 6'h03;
  localparam logic [5:0]  REG_STATUS     = 6'h04;
  localparam logic [5:0]  REG_CONTROL    = 6'h05;

  // device number field and addressing
  localparam int          DEVNUM_W       = 3;
  localparam logic [2:0]  DEV_BROADCAST  = 3'h0;
  localparam logic [2:0]  DEV_FIRST      = 3'h1;
  localparam logic [2:0]  DEV_LAST       = 3'h7;
  localparam logic [2:0]  DEVNUM_BASE    = 3'h1;  // device number for straps 00

  // identity codes: arbitrary neutral values
  localparam logic [15:0] MAKER_CODE     = 16'h0A5A;  // arbitrary value
  localparam logic [15:0] PART_REV_CODE  = 16'h0042;  // arbitrary value
  localparam logic [15:0] CAPS_VALUE     = 16'h0001;

  // status register fields
  localparam int          STAT_FLAG_BIT  = 0;
  localparam int          STAT_ERR_BIT   = 7;
  // control register fields
  localparam int          CTRL_EN_BIT    = 4;
  localparam logic        CTRL_EN_RESET  = 1'b0;

  // reset values
  localparam logic [2:0]  DEVNUM_RESET   = 3'h0;
  localparam logic [1:0]  STRAP_RESET    = 2'h0;

  // timing counts
  localparam int          SYNC_STAGES    = 3;     // strap synchroniser depth
  localparam logic [1:0]  STRAP_SETTLE   = 2'h3;  // cycles before straps are loaded
  localparam logic [2:0]  RSP_WAIT       = 3'h4;  // last count of the master answer window, which lasts 5 cycles

endpackage : snsid_pkg

// ===== snsid_if.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// transaction-level view of the single-wire bus between master and one slave
interface snsid_if;

  logic        req_valid;
  logic [2:0]  req_dev;
  logic [5:0]  req_addr;
  logic        req_write;
  logic [15:0] req_wdata;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic        even_parity_bit;
  logic        bus_idle;
  logic        attn_out;
  logic        attn_oe_n;
  logic        attn_line_n;

  // attention line: pulled high, driven low only while enable is low
  assign attn_line_n = attn_oe_n ? 1'b1 : attn_out;

  modport dev (
    input  req_valid, req_dev, req_addr, req_write, req_wdata, bus_idle,
    output rsp_valid, rsp_data, even_parity_bit, attn_out, attn_oe_n
  );

  modport mst (
    output req_valid, req_dev, req_addr, req_write, req_wdata, bus_idle,
    input  rsp_valid, rsp_data, even_parity_bit, attn_line_n
  );

endinterface : snsid_if

// ===== snsid_slave.sv
`timescale 1ns/100ps
// Notes on behaviour
// RULE_01: master latches every attention request seen
// RULE_02: master reads all status registers after attention
// RULE_03: attention pulse carries no source identity
// RULE_04: no repeated attention for pending events
// RULE_05: bus address comes only from straps
// RULE_06: device number loaded from straps after reset
// RULE_07: master discovers slaves by reading device number
// RULE_08: number field zero means address empty
// RULE_09: master ignores parity on presence reads
// RULE_10: function attention blocked until status read
// RULE_11: bus error always raises attention
module snsid_slave (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  snsid_if.dev      bus,
  input  wire logic addr_strap_lo,
  input  wire logic addr_strap_hi,
  input  wire logic func_event,
  input  wire logic bus_error_event,
  output logic [2:0] dev_number,
  output logic      func_attn_enabled,
  output logic      status_flag,
  output logic      bus_error_flag
);

  ////////////////////////////////////////////////////////////////////////////////
  // strap pins: three flip-flops, accept a level once stages two and three agree
  logic [1:0] strap_s1;
  logic [1:0] strap_s2;
  logic [1:0] strap_s3;
  wire        strap_agree = (strap_s2 == strap_s3);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      strap_s1     <= snsid_pkg::STRAP_RESET;
      strap_s2     <= snsid_pkg::STRAP_RESET;
      strap_s3     <= snsid_pkg::STRAP_RESET;
    end else begin
      strap_s1 <= {addr_strap_hi, addr_strap_lo};
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // device number load: once, from the third stage when it agrees with the second
  logic [1:0] settle_cnt;
  logic       dev_loaded;
  wire        settle_done = (settle_cnt == snsid_pkg::STRAP_SETTLE);
  wire  [2:0] next_dev_number = snsid_pkg::DEVNUM_BASE + {1'b0, strap_s3};

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      settle_cnt <= 2'h0;
      dev_loaded <= 1'b0;
      dev_number <= snsid_pkg::DEVNUM_RESET;
    end else begin
      if (!settle_done) begin
        settle_cnt <= settle_cnt + 2'h1;
      end
      if (settle_done && strap_agree && !dev_loaded) begin
        dev_loaded <= 1'b1;
        dev_number <= next_dev_number;  // RULE_06
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // request decode; the number register has no write path at all
  wire hit        = bus.req_valid && dev_loaded && (bus.req_dev == dev_number);  // RULE_05
  wire bcast      = bus.req_valid && dev_loaded &&
                    (bus.req_dev == snsid_pkg::DEV_BROADCAST);
  wire rd_hit     = hit && !bus.req_write;
  wire ctrl_wr    = (hit || bcast) && bus.req_write &&
                    (bus.req_addr == snsid_pkg::REG_CONTROL);
  wire status_rd  = rd_hit && (bus.req_addr == snsid_pkg::REG_STATUS);

  // status and control words as seen on the bus
  logic [15:0] status_word;
  logic [15:0] control_word;

  always_comb begin
    status_word                           = 16'h0000;
    status_word[snsid_pkg::STAT_FLAG_BIT] = status_flag;
    status_word[snsid_pkg::STAT_ERR_BIT]  = bus_error_flag;
    control_word                          = 16'h0000;
    control_word[snsid_pkg::CTRL_EN_BIT]  = func_attn_enabled;
  end

  // read data selection; unmapped addresses read as zero
  logic [15:0] rd_mux;

  always_comb begin
    case (bus.req_addr)
      snsid_pkg::REG_BUS_ADDR: rd_mux = {13'h0000, dev_number};
      snsid_pkg::REG_MAKER:    rd_mux = snsid_pkg::MAKER_CODE;
      snsid_pkg::REG_PART_REV: rd_mux = snsid_pkg::PART_REV_CODE;
      snsid_pkg::REG_CAPS:     rd_mux = snsid_pkg::CAPS_VALUE;
      snsid_pkg::REG_STATUS:   rd_mux = status_word;
      snsid_pkg::REG_CONTROL:  rd_mux = control_word;
      default:                 rd_mux = 16'h0000;
    endcase
  end

  // even parity over device number, address, read flag and data
  wire rd_parity = ^{dev_number, bus.req_addr, 1'b1, rd_mux};

  ////////////////////////////////////////////////////////////////////////////////
  // read answer: one cycle after the request, data held until the next answer
  logic        rsp_valid_q;
  logic [15:0] rsp_data_q;
  logic        rsp_parity_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rsp_valid_q  <= 1'b0;
      rsp_data_q   <= 16'h0000;
      rsp_parity_q <= 1'b0;
    end else begin
      rsp_valid_q <= rd_hit;
      if (rd_hit) begin
        rsp_data_q   <= rd_mux;
        rsp_parity_q <= rd_parity;
      end
    end
  end

  assign bus.rsp_valid       = rsp_valid_q;
  assign bus.rsp_data        = rsp_data_q;
  assign bus.even_parity_bit = rsp_parity_q;

  ////////////////////////////////////////////////////////////////////////////////
  // control register: attention enable for the function event
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      func_attn_enabled <= snsid_pkg::CTRL_EN_RESET;
    end else if (ctrl_wr) begin
      func_attn_enabled <= bus.req_wdata[snsid_pkg::CTRL_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky status flags: a new event wins over the clearing status read
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status_flag    <= 1'b0;
      bus_error_flag <= 1'b0;
    end else begin
      if (func_event) begin
        status_flag <= 1'b1;
      end else if (status_rd) begin
        status_flag <= 1'b0;
      end
      if (bus_error_event) begin
        bus_error_flag <= 1'b1;
      end else if (status_rd) begin
        bus_error_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // attention decision, taken at the first idle bus after each event
  logic fn_pend;
  logic err_pend;
  logic fn_blocked;
  logic attn_q;

  wire fn_fire   = fn_pend && !fn_blocked && bus.bus_idle;  // RULE_04 RULE_10
  wire err_fire  = err_pend && bus.bus_idle;                // RULE_11
  wire attn_fire = fn_fire || err_fire;

  // pending events wait for an idle bus; a blocked one is dropped there
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fn_pend  <= 1'b0;
      err_pend <= 1'b0;
    end else begin
      if (func_event && func_attn_enabled) begin
        fn_pend <= 1'b1;
      end else if (bus.bus_idle) begin
        fn_pend <= 1'b0;  // RULE_04
      end
      if (bus_error_event) begin
        err_pend <= 1'b1;
      end else if (bus.bus_idle) begin
        err_pend <= 1'b0;
      end
    end
  end

  // any request sent blocks function requests until status is read
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fn_blocked <= 1'b0;
    end else if (attn_fire) begin
      fn_blocked <= 1'b1;  // RULE_10
    end else if (status_rd) begin
      fn_blocked <= 1'b0;  // RULE_10
    end
  end

  // one-cycle low pulse on the shared line, same for every slave
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      attn_q <= 1'b0;
    end else begin
      attn_q <= attn_fire;
    end
  end

  assign bus.attn_out  = 1'b0;     // RULE_03
  assign bus.attn_oe_n = !attn_q;  // enable low while pulling the line

endmodule : snsid_slave

// ===== snsid_master.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// bus master: discovery, control writes and attention scans
module snsid_master (
  input  wire logic  clk_sys,
  input  wire logic  sys_rst,
  snsid_if.mst       bus,
  input  wire logic  discover_start,
  input  wire logic  cmd_write,
  input  wire logic [2:0]  cmd_dev,
  input  wire logic [15:0] cmd_wdata,
  output logic [7:0] present_mask,
  output logic       attn_latched,
  output logic       busy,
  output logic       ev_valid,
  output logic [2:0] ev_dev,
  output logic [15:0] ev_status,
  output logic       parity_err
);

  typedef enum {SN_IDLE, SN_REQ, SN_WAIT, SN_NEXT} snsid_state_t;
  typedef enum {SN_OP_DISC, SN_OP_SCAN, SN_OP_WRITE} snsid_op_t;

  snsid_state_t state;
  snsid_op_t    op;
  logic [2:0]   dev_idx;
  logic [2:0]   wait_cnt;
  logic         got_rsp;
  logic [15:0]  rsp_word;
  logic         rsp_par;
  logic [15:0]  wr_word;

  ////////////////////////////////////////////////////////////////////////////////
  // decode of the current step
  wire attn_seen   = !bus.attn_line_n;
  wire idle        = (state == SN_IDLE);
  wire start_disc  = idle && discover_start;
  wire start_wr    = idle && !discover_start && cmd_write;
  wire start_scan  = idle && !discover_start && !cmd_write && attn_latched;  // RULE_02
  wire wait_done   = (wait_cnt == snsid_pkg::RSP_WAIT);
  wire last_dev    = (dev_idx == snsid_pkg::DEV_LAST);
  wire [5:0] addr  = (op == SN_OP_DISC) ? snsid_pkg::REG_BUS_ADDR :
                     (op == SN_OP_SCAN) ? snsid_pkg::REG_STATUS : snsid_pkg::REG_CONTROL;
  wire exp_par     = ^{dev_idx, addr, 1'b1, rsp_word};
  wire dev_present = (rsp_word[2:0] != 3'h0);  // RULE_08
  wire skip_dev    = (op == SN_OP_SCAN) && !present_mask[dev_idx];

  assign bus.req_valid = (state == SN_REQ) && !skip_dev;
  assign bus.req_dev   = dev_idx;
  assign bus.req_addr  = addr;
  assign bus.req_write = (op == SN_OP_WRITE);
  assign bus.req_wdata = wr_word;
  assign bus.bus_idle  = idle;
  assign busy          = !idle;

  // latch attention; a new one during a scan survives its start
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      attn_latched <= 1'b0;
    end else if (attn_seen) begin
      attn_latched <= 1'b1;  // RULE_01
    end else if (start_scan) begin
      attn_latched <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // answer window: take the answer if one comes, else the line reads zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst || state != SN_WAIT) begin
      wait_cnt <= 3'h0;
      got_rsp  <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 3'h1;
      if (bus.rsp_valid) begin
        got_rsp <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || state == SN_REQ) begin
      rsp_word <= 16'h0000;
      rsp_par  <= 1'b0;
    end else if (state == SN_WAIT && bus.rsp_valid) begin
      rsp_word <= bus.rsp_data;
      rsp_par  <= bus.even_parity_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer over device numbers 1 to 7
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state   <= SN_IDLE;
      op      <= SN_OP_DISC;
      dev_idx <= snsid_pkg::DEV_FIRST;
      wr_word <= 16'h0000;
    end else begin
      case (state)
        SN_IDLE: begin
          dev_idx <= snsid_pkg::DEV_FIRST;
          if (start_disc) begin
            op    <= SN_OP_DISC;  // RULE_07
            state <= SN_REQ;
          end else if (start_wr) begin
            op      <= SN_OP_WRITE;
            dev_idx <= cmd_dev;
            wr_word <= cmd_wdata;
            state   <= SN_REQ;
          end else if (start_scan) begin
            op    <= SN_OP_SCAN;
            state <= SN_REQ;
          end
        end
        SN_REQ:  state <= skip_dev ? SN_NEXT : SN_WAIT;
        SN_WAIT: state <= wait_done ? SN_NEXT : SN_WAIT;
        SN_NEXT: begin
          dev_idx <= dev_idx + 3'h1;
          state   <= (last_dev || op == SN_OP_WRITE) ? SN_IDLE : SN_REQ;
        end
        default: state <= SN_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // results: presence map, events handed on, parity faults
  wire in_next    = (state == SN_NEXT);
  wire scan_ev    = in_next && op == SN_OP_SCAN && !skip_dev && rsp_word != 16'h0000;
  wire par_check  = in_next && op == SN_OP_SCAN && got_rsp;  // RULE_09

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      present_mask <= 8'h00;
      ev_valid     <= 1'b0;
      ev_dev       <= 3'h0;
      ev_status    <= 16'h0000;
      parity_err   <= 1'b0;
    end else begin
      if (in_next && op == SN_OP_DISC) begin
        present_mask[dev_idx] <= dev_present;  // RULE_08
      end
      ev_valid   <= scan_ev;  // RULE_02
      parity_err <= par_check && (rsp_par != exp_par);
      if (scan_ev) begin
        ev_dev    <= dev_idx;
        ev_status <= rsp_word;
      end
    end
  end

endmodule : snsid_master

// ===== snsid_assertions.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// checker on the bus between master and slave
module snsid_assertions (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        req_valid,
  input wire logic [2:0]  req_dev,
  input wire logic [5:0]  req_addr,
  input wire logic        req_write,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic        even_parity_bit,
  input wire logic        bus_idle,
  input wire logic        attn_line_n
);
  default clocking dflt_cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////////
  // answers, their contents and request spacing
  a_rsp_after_read: assert property (
    rsp_valid |-> $past(req_valid) && !$past(req_write))
    else $error("answer without a read request");
  a_no_broadcast_rsp: assert property (
    req_valid && req_dev == 3'h0 |=> !rsp_valid)
    else $error("answer to a broadcast request");
  a_devnum_read: assert property (
    (req_valid && !req_write && req_addr == snsid_pkg::REG_BUS_ADDR) ##1 rsp_valid
    |-> rsp_data == {13'h0000, $past(req_dev)})
    else $error("device number readback differs from address");
  a_parity_even: assert property (
    rsp_valid |-> !(^{$past(req_dev), $past(req_addr), 1'b1, rsp_data, even_parity_bit}))
    else $error("parity bit not even");
  a_req_spacing: assert property (
    req_valid |=> !req_valid [*5])
    else $error("requests too close together");

  ////////////////////////////////////////////////////////////////////////////////
  // attention line and the scan it triggers
  a_attn_one_cycle: assert property (
    $fell(attn_line_n) |=> attn_line_n)
    else $error("attention pulse longer than one cycle");
  a_attn_when_idle: assert property (
    !attn_line_n |-> $past(bus_idle))
    else $error("attention raised on a busy bus");
  a_master_goes_busy: assert property (
    $fell(attn_line_n) |-> ##[1:4] !bus_idle)
    else $error("attention not taken up by master");
  a_status_scanned: assert property (
    $fell(attn_line_n) |-> ##[1:80]
    (req_valid && !req_write && req_addr == snsid_pkg::REG_STATUS))
    else $error("no status read after attention");

  // main scenarios
  c_read_answer: cover property (rsp_valid);
  c_attention: cover property ($fell(attn_line_n));
  c_broadcast_write: cover property (req_valid && req_write && req_dev == 3'h0);
endmodule : snsid_assertions

// ===== tb_top.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// top bench: slave and master joined by the bus interface
module tb_top;
  typedef struct {
    logic       hi;
    logic       lo;
    logic [2:0] dev;
    logic [7:0] mask;
  } snsid_row_t;

  logic        clk_sys;
  logic        sys_rst;
  logic        addr_strap_lo;
  logic        addr_strap_hi;
  logic        func_event;
  logic        bus_error_event;
  logic [2:0]  dev_number;
  logic        func_attn_enabled;
  logic        status_flag;
  logic        bus_error_flag;
  logic        discover_start;
  logic        cmd_write;
  logic [2:0]  cmd_dev;
  logic [15:0] cmd_wdata;
  logic [7:0]  present_mask;
  logic        attn_latched;
  logic        busy;
  logic        ev_valid;
  logic [2:0]  ev_dev;
  logic [15:0] ev_status;
  logic        parity_err;
  int          n_errors;
  int          num_checks;
  int          attn_count;
  int          ev_count;
  int          par_count;
  int          a0;
  int          e0;
  snsid_row_t  rows [4];

  snsid_if i_snsid_if ();

  snsid_slave i_snsid_slave (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus(i_snsid_if),
    .addr_strap_lo(addr_strap_lo), .addr_strap_hi(addr_strap_hi),
    .func_event(func_event), .bus_error_event(bus_error_event),
    .dev_number(dev_number), .func_attn_enabled(func_attn_enabled),
    .status_flag(status_flag), .bus_error_flag(bus_error_flag)
  );

  snsid_master i_snsid_master (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus(i_snsid_if),
    .discover_start(discover_start), .cmd_write(cmd_write), .cmd_dev(cmd_dev),
    .cmd_wdata(cmd_wdata), .present_mask(present_mask), .attn_latched(attn_latched),
    .busy(busy), .ev_valid(ev_valid), .ev_dev(ev_dev), .ev_status(ev_status),
    .parity_err(parity_err)
  );

  snsid_assertions i_snsid_assertions (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .req_valid(i_snsid_if.req_valid),
    .req_dev(i_snsid_if.req_dev), .req_addr(i_snsid_if.req_addr),
    .req_write(i_snsid_if.req_write), .rsp_valid(i_snsid_if.rsp_valid),
    .rsp_data(i_snsid_if.rsp_data), .even_parity_bit(i_snsid_if.even_parity_bit),
    .bus_idle(i_snsid_if.bus_idle), .attn_line_n(i_snsid_if.attn_line_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock, pulse counters and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (i_snsid_if.attn_line_n === 1'b0) attn_count++;
    if (ev_valid === 1'b1) ev_count++;
    if (parity_err !== 1'b0) par_count++;
  end

  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helper tasks
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  task automatic wait_idle;
    int k;
    k = 0;
    tick(5);
    while (busy !== 1'b0 && k < 400) begin
      tick(1);
      k++;
    end
    if (k >= 400) n_errors++;
  endtask : wait_idle

  task automatic do_reset(input logic hi, input logic lo);
    addr_strap_hi = hi;
    addr_strap_lo = lo;
    sys_rst = 1'b1;
    tick(4);
    sys_rst = 1'b0;
    tick(6);
  endtask : do_reset

  task automatic write_cmd(input logic [2:0] dev, input logic [15:0] data);
    cmd_dev = dev;
    cmd_wdata = data;
    cmd_write = 1'b1;
    tick(1);
    cmd_write = 1'b0;
    wait_idle();
  endtask : write_cmd

  task automatic mark;
    a0 = attn_count;
    e0 = ev_count;
  endtask : mark

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    func_event = 1'b0;
    bus_error_event = 1'b0;
    discover_start = 1'b0;
    cmd_write = 1'b0;
    cmd_dev = 3'h0;
    cmd_wdata = 16'h0000;
    rows = '{'{1'b0, 1'b0, 3'h1, 8'h02}, '{1'b0, 1'b1, 3'h2, 8'h04},
             '{1'b1, 1'b0, 3'h3, 8'h08}, '{1'b1, 1'b1, 3'h4, 8'h10}};
    // strap table: number loaded at reset, found by discovery
    foreach (rows[i]) begin
      do_reset(rows[i].hi, rows[i].lo);
      check(16'(dev_number), 16'(rows[i].dev));
      discover_start = 1'b1;
      tick(1);
      discover_start = 1'b0;
      wait_idle();
      check(16'(present_mask), 16'(rows[i].mask));
    end
    // straps moved after reset leave the number alone
    addr_strap_hi = 1'b0;
    tick(10);
    check(16'(dev_number), 16'h0004);
    // broadcast enable, then a function event
    write_cmd(3'h0, 16'h0010);
    check(16'(func_attn_enabled), 16'h0001);
    mark();
    func_event = 1'b1;
    tick(1);
    func_event = 1'b0;
    wait_idle();
    check(16'(attn_count - a0), 16'h0001);
    check(16'(ev_count - e0), 16'h0001);
    check(16'(ev_dev), 16'h0004);
    check(16'(ev_status[0]), 16'h0001);
    check(16'(status_flag), 16'h0000);
    check(16'(attn_latched), 16'h0000);
    // two events back to back give one attention
    mark();
    func_event = 1'b1;
    tick(2);
    func_event = 1'b0;
    wait_idle();
    check(16'(attn_count - a0), 16'h0001);
    check(16'(ev_count - e0), 16'h0001);
    // bus error raises attention and is reported
    mark();
    bus_error_event = 1'b1;
    tick(1);
    bus_error_event = 1'b0;
    wait_idle();
    check(16'(attn_count - a0), 16'h0001);
    check(ev_status, 16'h0080);
    check(16'(bus_error_flag), 16'h0000);
    // attention disabled: event kept silent until an error comes
    write_cmd(3'h4, 16'h0000);
    mark();
    func_event = 1'b1;
    tick(1);
    func_event = 1'b0;
    tick(10);
    check(16'(attn_count - a0), 16'h0000);
    check(16'(status_flag), 16'h0001);
    bus_error_event = 1'b1;
    tick(1);
    bus_error_event = 1'b0;
    wait_idle();
    check(16'(attn_count - a0), 16'h0001);
    check(ev_status, 16'h0081);
    check(16'(par_count), 16'h0000);
    // enable again so that the reset below has something to clear
    write_cmd(3'h4, 16'h0010);
    check(16'(func_attn_enabled), 16'h0001);
    // fifth reset picks up the new strap level
    do_reset(1'b0, 1'b1);
    check(16'(dev_number), 16'h0002);
    check(16'(func_attn_enabled), 16'h0000);
    check(16'(present_mask), 16'h0000);
    tally_and_finish();
  end
endmodule : tb_top
